// ==== bsbmd_map.vh ====
// Constants, encodings and register map of the branch, system control and block move core
// Functional notes
// - A conditional branch jumps to its target only when its condition is true.
// - Conditions: always, never, higher, lower-or-same, carry clear, carry set.
// - Conditions: not equal, equal, overflow clear/set, plus, minus.
// - Signed conditions: ge, lt, gt, le from N xor V and Z.
// - The unconditional jump always loads the program counter with its target.
// - Relative and absolute calls push a return point; return resumes there.
// - The trap instruction starts trap exception handling.
// - Exception return ends a handler and resumes the interrupted program.
// - The sleep instruction enters a power-down state.
// - Load flags copies a byte into the flag register; memory source uses word read.
// - Store flags copies the flag register out; memory destination uses word write.
// - Flag logic ANDs, ORs or XORs the flag register with a byte immediate.
// - No-operation only advances the program counter by 2.
// - Byte-count move skips on zero, else copies bytes with pointer increments.
// - Word-count move is the same but counts with the 16-bit count register.
// - The next instruction starts right after the whole move completes.
// - Instructions are built from 2-byte words with op, register, extension, condition.
// - The operation field is the top four bits; some carry a second one.
// - Address registers use 3-bit fields, data registers 3 or 4 bits.
// - Extensions are 8, 16 or 32 bits; 24-bit values have a zero top byte.
// - Upper address bits are ignored; memory addresses are 16 bits.
`ifndef BSBMD_MAP_VH
`define BSBMD_MAP_VH
// ==========================================
// Operation field and second operation field
`define BSBMD_OP_SYS 4'h0
`define BSBMD_OP_BRANCH 4'h4
`define BSBMD_OP_JUMP 4'h5
`define BSBMD_OP_CALL_REL 4'h6
`define BSBMD_OP_CALL_ABS 4'h7
`define BSBMD_SUB_NO_OPERATION 4'h0
`define BSBMD_SUB_SLEEP 4'h1
`define BSBMD_SUB_RETURN_SUB 4'h2
`define BSBMD_SUB_RETURN_EXC 4'h3
`define BSBMD_SUB_TRAP 4'h4
`define BSBMD_SUB_LOAD_FLAGS_REG 4'h5
`define BSBMD_SUB_STORE_FLAGS_REG 4'h6
`define BSBMD_SUB_LOAD_FLAGS_MEM 4'h7
`define BSBMD_SUB_STORE_FLAGS_MEM 4'h8
`define BSBMD_SUB_AND_FLAGS 4'h9
`define BSBMD_SUB_OR_FLAGS 4'ha
`define BSBMD_SUB_XOR_FLAGS 4'hb
`define BSBMD_SUB_MOVE_BYTECOUNT 4'hc
`define BSBMD_SUB_MOVE_WORDCOUNT 4'hd
`define BSBMD_EXT_ABS8 2'h0
`define BSBMD_EXT_ABS16 2'h1
`define BSBMD_EXT_ABS32 2'h2
`define BSBMD_ABS8_HIGH 8'hff
// ==========================================
// Flag bits, registers, vectors
`define BSBMD_CCR_C 0
`define BSBMD_CCR_V 1
`define BSBMD_CCR_Z 2
`define BSBMD_CCR_N 3
`define BSBMD_CCR_I 7
`define BSBMD_CCR_RESET 8'h80
`define BSBMD_PC_RESET 16'h0100
`define BSBMD_TRAP_VEC_BASE 16'h0010
`define BSBMD_IDX_COUNT 3'h4
`define BSBMD_IDX_SRC 3'h5
`define BSBMD_IDX_DST 3'h6
`define BSBMD_IDX_SP 3'h7
// ==========================================
// Register bus map and responses
`define BSBMD_A_CTRL 8'h00
`define BSBMD_A_STAT 8'h04
`define BSBMD_A_PC 8'h08
`define BSBMD_A_CCR 8'h0c
`define BSBMD_A_GPR_HI 3'h1
`define BSBMD_RESP_OKAY 2'h0
`define BSBMD_RESP_SLVERR 2'h2
`endif

// ==== bsbmd_core.v ====
// Branch, system control and block move execution core with register bus slave
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`include "bsbmd_map.vh"
module bsbmd_core (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register bus write
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    // Register bus read
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    input wire [7:0] s_axi_araddr,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    // Memory port
    output reg memReq_q,
    output reg memWe_q,
    output reg memByte_q,
    output reg [15:0] memAddr_q,
    output reg [15:0] memWdata_q,
    input wire [15:0] memRdata,
    input wire memAck,
    // Datapath flags and power state
    input wire flagsWe,
    input wire [7:0] flagsIn,
    output wire [7:0] flagsOut,
    input wire wakeIn,
    output wire sleeping
);
    // ==========================================
    // States
    localparam [9:0] S_IDLE = 10'h001;
    localparam [9:0] S_FETCH = 10'h002;
    localparam [9:0] S_DEC = 10'h004;
    localparam [9:0] S_EXT = 10'h008;
    localparam [9:0] S_XCAP = 10'h010;
    localparam [9:0] S_EXEC = 10'h020;
    localparam [9:0] S_WAIT = 10'h040;
    localparam [9:0] S_SEQ = 10'h080;
    localparam [9:0] S_MOVE = 10'h100;
    localparam [9:0] S_SLEEP = 10'h200;

    reg [9:0] stateQ;
    reg [9:0] retQ;
    reg [15:0] pcQ;
    reg [7:0] ccrQ;
    reg [15:0] irQ;
    reg [31:0] extQ;
    reg [1:0] extCntQ;
    reg [15:0] rdQ;
    reg [1:0] seqQ;
    reg runQ;
    reg [31:0] gpr [0:7];
    integer i;

    // ==========================================
    // Functions
    function condTrue;
        input [3:0] cc;
        input [7:0] f;
        reg t;
        begin
            case (cc[3:1])
                3'h0: t = 1'b1;
                3'h1: t = ~(f[`BSBMD_CCR_C] | f[`BSBMD_CCR_Z]);
                3'h2: t = ~f[`BSBMD_CCR_C];
                3'h3: t = ~f[`BSBMD_CCR_Z];
                3'h4: t = ~f[`BSBMD_CCR_V];
                3'h5: t = ~f[`BSBMD_CCR_N];
                3'h6: t = ~(f[`BSBMD_CCR_N] ^ f[`BSBMD_CCR_V]);
                default: t = ~(f[`BSBMD_CCR_Z] | (f[`BSBMD_CCR_N] ^ f[`BSBMD_CCR_V]));
            endcase
            // Odd codes are the negation of the even code below them
            condTrue = t ^ cc[0];
        end
    endfunction

    function [1:0] extWords;
        input [15:0] ir;
        begin
            extWords = 2'h0;
            if (ir[15:12] == `BSBMD_OP_JUMP || ir[15:12] == `BSBMD_OP_CALL_ABS) begin
                if (ir[1:0] == `BSBMD_EXT_ABS16) begin
                    extWords = 2'h1;
                end else if (ir[1:0] == `BSBMD_EXT_ABS32) begin
                    extWords = 2'h2;
                end
            end
        end
    endfunction

    function [15:0] absTarget;
        input [15:0] ir;
        input [31:0] ext;
        begin
            // Top address bits of a 32-bit extension are dropped
            if (ir[1:0] == `BSBMD_EXT_ABS8) begin
                absTarget = {`BSBMD_ABS8_HIGH, ir[11:4]};
            end else begin
                absTarget = ext[15:0];
            end
        end
    endfunction

    function [31:0] mergeW;
        input [31:0] old;
        input [31:0] d;
        input [3:0] strb;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                mergeW[k*8 +: 8] = strb[k] ? d[k*8 +: 8] : old[k*8 +: 8];
            end
        end
    endfunction

    // ==========================================
    // Bus handshakes
    wire wrTake = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    wire idle = (stateQ == S_IDLE);
    wire gprWrHit = (s_axi_awaddr[7:5] == `BSBMD_A_GPR_HI) && (s_axi_awaddr[1:0] == 2'h0);
    wire gprRdHit = (s_axi_araddr[7:5] == `BSBMD_A_GPR_HI) && (s_axi_araddr[1:0] == 2'h0);
    wire [15:0] sp = gpr[`BSBMD_IDX_SP][15:0];
    wire [3:0] sub = irQ[11:8];
    wire moveWide = (sub == `BSBMD_SUB_MOVE_WORDCOUNT);
    wire [15:0] moveCount = moveWide ? gpr[`BSBMD_IDX_COUNT][15:0]
                                     : {8'h00, gpr[`BSBMD_IDX_COUNT][7:0]};
    wire [31:0] srcReg = gpr[irQ[6:4]];
    wire [7:0] srcByte = irQ[3] ? srcReg[7:0] : srcReg[15:8];
    wire [31:0] pcNew = mergeW({16'h0000, pcQ}, s_axi_wdata, s_axi_wstrb);

    assign s_axi_awready = wrTake;
    assign s_axi_wready = wrTake;
    assign s_axi_arready = ~s_axi_rvalid;
    assign flagsOut = ccrQ;
    assign sleeping = (stateQ == S_SLEEP);

    task memIssue;
        input we;
        input bt;
        input [15:0] a;
        input [15:0] d;
        input [9:0] r;
        begin
            memReq_q <= 1'b1;
            memWe_q <= we;
            memByte_q <= bt;
            memAddr_q <= a;
            memWdata_q <= d;
            retQ <= r;
            stateQ <= S_WAIT;
        end
    endtask

    // ==========================================
    // Register bus responses
    always @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BSBMD_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `BSBMD_RESP_OKAY;
        end else begin
            if (wrTake) begin
                s_axi_bvalid <= 1'b1;
                if (gprWrHit || s_axi_awaddr == `BSBMD_A_CTRL || s_axi_awaddr == `BSBMD_A_PC
                    || s_axi_awaddr == `BSBMD_A_CCR || s_axi_awaddr == `BSBMD_A_STAT) begin
                    s_axi_bresp <= `BSBMD_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `BSBMD_RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `BSBMD_RESP_OKAY;
                if (s_axi_araddr == `BSBMD_A_CTRL) begin
                    s_axi_rdata <= {31'h00000000, runQ};
                end else if (s_axi_araddr == `BSBMD_A_STAT) begin
                    s_axi_rdata <= {29'h00000000, stateQ == S_MOVE, sleeping, idle};
                end else if (s_axi_araddr == `BSBMD_A_PC) begin
                    s_axi_rdata <= {16'h0000, pcQ};
                end else if (s_axi_araddr == `BSBMD_A_CCR) begin
                    s_axi_rdata <= {24'h000000, ccrQ};
                end else if (gprRdHit) begin
                    s_axi_rdata <= gpr[s_axi_araddr[4:2]];
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `BSBMD_RESP_SLVERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // Sequencer
    always @(posedge clk) begin
        if (rst) begin
            stateQ <= S_IDLE;
            retQ <= S_IDLE;
            pcQ <= `BSBMD_PC_RESET;
            ccrQ <= `BSBMD_CCR_RESET;
            irQ <= 16'h0000;
            extQ <= 32'h00000000;
            extCntQ <= 2'h0;
            rdQ <= 16'h0000;
            seqQ <= 2'h0;
            runQ <= 1'b0;
            memReq_q <= 1'b0;
            memWe_q <= 1'b0;
            memByte_q <= 1'b0;
            memAddr_q <= 16'h0000;
            memWdata_q <= 16'h0000;
            for (i = 0; i < 8; i = i + 1) begin
                gpr[i] <= 32'h00000000;
            end
        end else begin
            memReq_q <= 1'b0;
            // Datapath flag updates lose to this block's own flag writes below
            if (flagsWe) begin
                ccrQ <= flagsIn;
            end
            // Software may load state only while stopped, so no write races the core
            if (wrTake) begin
                if (s_axi_awaddr == `BSBMD_A_CTRL && s_axi_wstrb[0]) begin
                    runQ <= s_axi_wdata[0];
                end else if (idle && s_axi_awaddr == `BSBMD_A_PC) begin
                    pcQ <= pcNew[15:0];
                end else if (idle && s_axi_awaddr == `BSBMD_A_CCR && s_axi_wstrb[0]) begin
                    ccrQ <= s_axi_wdata[7:0];
                end else if (idle && gprWrHit) begin
                    gpr[s_axi_awaddr[4:2]] <= mergeW(gpr[s_axi_awaddr[4:2]], s_axi_wdata,
                                                     s_axi_wstrb);
                end
            end
            case (stateQ)
                S_IDLE: begin
                    if (runQ) begin
                        stateQ <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    // Stop is honoured only between instructions
                    if (!runQ) begin
                        stateQ <= S_IDLE;
                    end else begin
                        memIssue(1'b0, 1'b0, pcQ, 16'h0000, S_DEC);
                        pcQ <= pcQ + 16'h0002;
                    end
                end
                S_WAIT: begin
                    if (memAck) begin
                        rdQ <= memRdata;
                        stateQ <= retQ;
                    end
                end
                S_DEC: begin
                    irQ <= rdQ;
                    extQ <= 32'h00000000;
                    extCntQ <= extWords(rdQ);
                    stateQ <= (extWords(rdQ) == 2'h0) ? S_EXEC : S_EXT;
                end
                S_EXT: begin
                    memIssue(1'b0, 1'b0, pcQ, 16'h0000, S_XCAP);
                    pcQ <= pcQ + 16'h0002;
                end
                S_XCAP: begin
                    extQ <= {extQ[15:0], rdQ};
                    extCntQ <= extCntQ - 2'h1;
                    stateQ <= (extCntQ == 2'h1) ? S_EXEC : S_EXT;
                end
                S_EXEC: begin
                    seqQ <= 2'h0;
                    stateQ <= S_FETCH;
                    case (irQ[15:12])
                        `BSBMD_OP_BRANCH: begin
                            // pcQ already holds the following instruction
                            if (condTrue(irQ[11:8], ccrQ)) begin
                                pcQ <= pcQ + {{8{irQ[7]}}, irQ[7:0]};
                            end
                        end
                        `BSBMD_OP_JUMP: begin
                            pcQ <= absTarget(irQ, extQ);
                        end
                        `BSBMD_OP_CALL_REL: begin
                            memIssue(1'b1, 1'b0, sp - 16'h0002, pcQ, S_FETCH);
                            gpr[`BSBMD_IDX_SP] <= gpr[`BSBMD_IDX_SP] - 32'h00000002;
                            pcQ <= pcQ + {{8{irQ[7]}}, irQ[7:0]};
                        end
                        `BSBMD_OP_CALL_ABS: begin
                            memIssue(1'b1, 1'b0, sp - 16'h0002, pcQ, S_FETCH);
                            gpr[`BSBMD_IDX_SP] <= gpr[`BSBMD_IDX_SP] - 32'h00000002;
                            pcQ <= absTarget(irQ, extQ);
                        end
                        `BSBMD_OP_SYS: begin
                            case (sub)
                                `BSBMD_SUB_SLEEP: stateQ <= S_SLEEP;
                                `BSBMD_SUB_RETURN_SUB: begin
                                    memIssue(1'b0, 1'b0, sp, 16'h0000, S_SEQ);
                                end
                                `BSBMD_SUB_RETURN_EXC: begin
                                    memIssue(1'b0, 1'b0, sp, 16'h0000, S_SEQ);
                                end
                                `BSBMD_SUB_TRAP: begin
                                    memIssue(1'b1, 1'b0, sp - 16'h0002, pcQ, S_SEQ);
                                    gpr[`BSBMD_IDX_SP] <= gpr[`BSBMD_IDX_SP] - 32'h00000002;
                                end
                                `BSBMD_SUB_LOAD_FLAGS_REG: ccrQ <= srcByte;
                                `BSBMD_SUB_STORE_FLAGS_REG: begin
                                    if (irQ[3]) begin
                                        gpr[irQ[6:4]][7:0] <= ccrQ;
                                    end else begin
                                        gpr[irQ[6:4]][15:8] <= ccrQ;
                                    end
                                end
                                `BSBMD_SUB_LOAD_FLAGS_MEM: begin
                                    memIssue(1'b0, 1'b0, srcReg[15:0], 16'h0000, S_SEQ);
                                end
                                `BSBMD_SUB_STORE_FLAGS_MEM: begin
                                    memIssue(1'b1, 1'b0, srcReg[15:0], {ccrQ, 8'h00},
                                             S_FETCH);
                                end
                                `BSBMD_SUB_AND_FLAGS: ccrQ <= ccrQ & irQ[7:0];
                                `BSBMD_SUB_OR_FLAGS: ccrQ <= ccrQ | irQ[7:0];
                                `BSBMD_SUB_XOR_FLAGS: ccrQ <= ccrQ ^ irQ[7:0];
                                `BSBMD_SUB_MOVE_BYTECOUNT, `BSBMD_SUB_MOVE_WORDCOUNT: begin
                                    if (moveCount != 16'h0000) begin
                                        stateQ <= S_MOVE;
                                    end
                                end
                                default: stateQ <= S_FETCH;
                            endcase
                        end
                        default: stateQ <= S_FETCH;
                    endcase
                end
                S_SEQ: begin
                    seqQ <= seqQ + 2'h1;
                    stateQ <= S_FETCH;
                    case (sub)
                        `BSBMD_SUB_RETURN_SUB: begin
                            pcQ <= rdQ;
                            gpr[`BSBMD_IDX_SP] <= gpr[`BSBMD_IDX_SP] + 32'h00000002;
                        end
                        `BSBMD_SUB_RETURN_EXC: begin
                            if (seqQ == 2'h0) begin
                                ccrQ <= rdQ[15:8];
                                memIssue(1'b0, 1'b0, sp + 16'h0002, 16'h0000, S_SEQ);
                            end else begin
                                pcQ <= rdQ;
                                gpr[`BSBMD_IDX_SP] <= gpr[`BSBMD_IDX_SP] + 32'h00000004;
                            end
                        end
                        `BSBMD_SUB_TRAP: begin
                            if (seqQ == 2'h0) begin
                                memIssue(1'b1, 1'b0, sp - 16'h0002, {ccrQ, 8'h00}, S_SEQ);
                                gpr[`BSBMD_IDX_SP] <= gpr[`BSBMD_IDX_SP] - 32'h00000002;
                            end else if (seqQ == 2'h1) begin
                                // Mask further interrupts inside the handler
                                ccrQ[`BSBMD_CCR_I] <= 1'b1;
                                memIssue(1'b0, 1'b0, `BSBMD_TRAP_VEC_BASE + {13'h0000,
                                         irQ[5:4], 1'b0}, 16'h0000, S_SEQ);
                            end else begin
                                pcQ <= rdQ;
                            end
                        end
                        default: ccrQ <= rdQ[15:8];
                    endcase
                end
                S_MOVE: begin
                    if (seqQ == 2'h0) begin
                        seqQ <= 2'h1;
                        memIssue(1'b0, 1'b1, gpr[`BSBMD_IDX_SRC][15:0], 16'h0000,
                                 S_MOVE);
                    end else begin
                        seqQ <= 2'h0;
                        // Fetch resumes the cycle after the last write is acknowledged
                        memIssue(1'b1, 1'b1, gpr[`BSBMD_IDX_DST][15:0], {8'h00, rdQ[7:0]},
                                 (moveCount == 16'h0001) ? S_FETCH : S_MOVE);
                        gpr[`BSBMD_IDX_SRC] <= gpr[`BSBMD_IDX_SRC] + 32'h00000001;
                        gpr[`BSBMD_IDX_DST] <= gpr[`BSBMD_IDX_DST] + 32'h00000001;
                        if (moveWide) begin
                            gpr[`BSBMD_IDX_COUNT][15:0] <= moveCount - 16'h0001;
                        end else begin
                            gpr[`BSBMD_IDX_COUNT][7:0] <= moveCount[7:0] - 8'h01;
                        end
                    end
                end
                S_SLEEP: begin
                    if (wakeIn) begin
                        stateQ <= S_FETCH;
                    end else if (!runQ) begin
                        stateQ <= S_IDLE;
                    end
                end
                default: stateQ <= S_IDLE;
            endcase
        end
    end
endmodule

// ==== bsbmd_checker.sv ====
// Assertion checker for the branch, system control and block move core
`include "bsbmd_map.vh"
module bsbmd_checker (
    // Clock, reset and register bus
    input wire logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_bvalid, s_axi_bready,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [1:0] s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    // Memory port and state
    input wire logic memReq_q, memWe_q, memByte_q, memAck, sleeping, wakeIn,
    input wire logic [7:0] flagsOut
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Register bus
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write answer late");
    wr_accept_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer stuck");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'hf0
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
    // ==========================================
    // Memory port and power state
    mem_pulse_a: assert property (memReq_q |=> !memReq_q)
        else $error("request not a pulse");
    mem_order_a: assert property (memAck |-> !memReq_q)
        else $error("request overlaps answer");
    sleep_quiet_a: assert property (sleeping && !wakeIn |=> !memReq_q)
        else $error("fetch while asleep");
    reset_state_a: assert property ($fell(rst) |-> flagsOut == `BSBMD_CCR_RESET && !sleeping)
        else $error("bad state after reset");
    cover property (memReq_q && memWe_q && memByte_q);
    cover property ($rose(sleeping));
    cover property (memReq_q && memWe_q && !memByte_q);
endmodule
bind bsbmd_core bsbmd_checker bsbmd_checker_inst (.*);

// ==== bsbmd_mem.sv ====
// Memory model answering the core's fetches, reads and writes
module bsbmd_mem (
    // Clock and pace
    input wire logic clk, slow,
    // Memory port
    input wire logic memReq_q, memWe_q, memByte_q,
    input wire logic [15:0] memAddr_q, memWdata_q,
    output logic [15:0] memRdata = 16'h0000,
    output logic memAck = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    logic busy_q = 1'b0;
    logic [1:0] wait_q = 2'h0;
    wire [15:0] a = {memAddr_q[15:1], 1'b0};
    // Data off the answer cycle keeps toggling, so an early sample never matches
    always @(posedge clk) begin
        memAck <= 1'b0;
        memRdata <= ~memRdata;
        if (memReq_q) begin
            busy_q <= 1'b1;
            wait_q <= {slow, slow};
        end else if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
        end else if (busy_q) begin
            busy_q <= 1'b0;
            memAck <= 1'b1;
            if (memWe_q && memByte_q) mem[memAddr_q] <= memWdata_q[7:0];
            else if (memWe_q) {mem[a], mem[a + 16'h1]} <= memWdata_q;
            else if (memByte_q) memRdata <= {8'h00, mem[memAddr_q]};
            else memRdata <= {mem[a], mem[a + 16'h1]};
        end
    end
endmodule

// ==== bsbmd_core_test.sv ====
// Testbench running small programs on the core against the memory model
module bsbmd_core_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, slow = 1'b0, flagsWe = 1'b0, wakeIn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, flagsIn = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire memReq_q, memWe_q, memByte_q, memAck, sleeping;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] memAddr_q, memWdata_q, memRdata;
    wire [7:0] flagsOut;
    int fails = 0, comparisons = 0, cyc = 0;
    logic [7:0] pat [4] = '{8'h00, 8'h05, 8'h0a, 8'h08};
    logic [15:0] prog [14] = '{16'h0400, 16'h6004, 16'h5001, 16'h0112, 16'h0a0f, 16'h09f3,
        16'h0b81, 16'h0830, 16'h0200, 16'h0000, 16'h0c00, 16'h0d00, 16'h0100, 16'h0300};
    bsbmd_core bsbmd_core_inst (.*);
    bsbmd_mem bsbmd_mem_inst (.*);
    initial forever #50 clk = ~clk;
    // ==========================================
    // Tasks
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One transfer at a time; for reads d is the expected data
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] r);
        s_axi_awvalid <= we;
        s_axi_wvalid <= we;
        s_axi_arvalid <= !we;
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_bready <= we;
        s_axi_rready <= !we;
        @(posedge clk);
        while (we ? !s_axi_awready : !s_axi_arready) @(posedge clk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
        while (!(we ? s_axi_bvalid : s_axi_rvalid)) @(posedge clk);
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        cmp("response", {30'h0, r}, {30'h0, we ? s_axi_bresp : s_axi_rresp});
        if (!we) cmp("read data", d, s_axi_rdata);
        @(posedge clk);
    endtask
    task automatic putw(input logic [15:0] a, input logic [15:0] w);
        {bsbmd_mem_inst.mem[a], bsbmd_mem_inst.mem[a + 16'h1]} = w;
    endtask
    function automatic logic br(input logic [3:0] c, input logic [7:0] f);
        logic [7:0] b;
        b = {!(f[2] | (f[3] ^ f[1])), !(f[3] ^ f[1]), !f[3], !f[1], !f[2], !f[0],
            !(f[0] | f[2]), 1'b1};
        return b[c[3:1]] ^ c[0];
    endfunction
    // Starts at 0x0100 with the given flags and stops once the core sleeps
    task automatic run(input logic [7:0] f);
        bus(1'b1, 8'h08, 32'h100, 2'h0);
        bus(1'b1, 8'h0c, {24'h0, f}, 2'h0);
        bus(1'b1, 8'h00, 32'h1, 2'h0);
        repeat (3000) if (!sleeping) @(posedge clk);
        cmp("sleeping", 32'h1, {31'h0, sleeping});
        bus(1'b1, 8'h00, 32'h0, 2'h0);
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            tally_and_finish();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, 8'h08, 32'h100, 2'h0);
        bus(1'b0, 8'h0c, 32'h80, 2'h0);
        bus(1'b0, 8'hf0, 32'h0, 2'h2);
        bus(1'b1, 8'hf0, 32'h0, 2'h2);
        for (int i = 0; i < 64; i++) begin
            putw(16'h100, {4'h4, i[5:2], 8'h10});
            putw(16'h102, 16'h0100);
            putw(16'h112, 16'h0100);
            run(pat[i[1:0]]);
            cmp("branch", br(i[5:2], pat[i[1:0]]) ? 16'h112 : 16'h102, memAddr_q);
        end
        putw(16'h10, 16'h011a);
        for (int i = 0; i < 14; i++) putw(16'h100 + 16'(2 * i), prog[i]);
        putw(16'h300, 16'ha1b2);
        putw(16'h302, 16'hc300);
        for (int i = 3; i < 8; i++) bus(1'b1, 8'h20 + 8'(4 * i), i == 3 ? 32'h500 : i == 4 ? 32'h3 : i == 7 ? 32'h800 : 32'h100 * (i - 2), 2'h0);
        slow <= 1'b1;
        run(8'h80);
        cmp("stop address", 32'h118, {16'h0, memAddr_q});
        bus(1'b0, 8'h0c, 32'h02, 2'h0);
        cmp("stored flags", 32'h02, {24'h0, bsbmd_mem_inst.mem[16'h500]});
        cmp("trap frame", 32'h80, {24'h0, bsbmd_mem_inst.mem[16'h7fc]});
        cmp("return point", 32'h0104, {16'h0, bsbmd_mem_inst.mem[16'h7fe], bsbmd_mem_inst.mem[16'h7ff]});
        cmp("moved bytes", 32'ha1b2c3, {8'h0, bsbmd_mem_inst.mem[16'h400], bsbmd_mem_inst.mem[16'h401], bsbmd_mem_inst.mem[16'h402]});
        bus(1'b0, 8'h30, 32'h0, 2'h0);
        bus(1'b0, 8'h34, 32'h303, 2'h0);
        bus(1'b0, 8'h38, 32'h403, 2'h0);
        bus(1'b0, 8'h3c, 32'h800, 2'h0);
        tally_and_finish();
    end
endmodule
